// >>> shift_storage_cfg.svh
// Offsets, field positions, reset values and sizes of the shift/storage register block
`ifndef SHIFT_STORAGE_CFG_SVH
`define SHIFT_STORAGE_CFG_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define SSR_WIDTH           8
`define SSR_FIFO_DEPTH      16
`define SSR_ADDR_WIDTH      12

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SSR_ADDR_CTRL       12'h000
`define SSR_ADDR_STATUS     12'h004
`define SSR_ADDR_PRESET     12'h008
`define SSR_ADDR_LOADS      12'h00c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SSR_CTRL_PRESET_SRC 0
`define SSR_CTRL_FLUSH      1
`define SSR_STAT_OE         8
`define SSR_STAT_FULL       9
`define SSR_STAT_EMPTY      10
`define SSR_STAT_LEVEL_LO   11

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SSR_REG_RESET       8'h00
`define SSR_LOADS_RESET     16'h0000

`endif

// >>> shift_storage_pkg.sv
// Types shared by the shift/storage register block
package shift_storage_pkg;

	// ------------------------------------------------------------------------
	// Operation selected by {op_select_hi, op_select_lo}
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_HOLD  = 2'b00,
		MODE_RIGHT = 2'b01,
		MODE_LOAD  = 2'b11,
		MODE_LEFT  = 2'b10
	} op_mode_e;

	// ------------------------------------------------------------------------
	// One sample of every pin input
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic       sync_clear_n;
		logic       op_select_hi;
		logic       op_select_lo;
		logic       pin_drive_en_a_n;
		logic       pin_drive_en_b_n;
		logic       serial_in_right;
		logic       serial_in_left;
		logic [7:0] shared_bus_pins;
	} pin_sample_s;

endpackage

// >>> preset_fifo.sv
// Small FIFO holding preset words for parallel loads
`timescale 1ns/1ps
module preset_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         reset_n_i,
	input  wire logic                         flush_i,
	// Fill side
	input  wire logic                         in_valid_i,
	output logic                              in_ready_o,
	input  wire logic [WIDTH-1:0]             in_data_i,
	// Drain side
	output logic                              out_valid_o,
	input  wire logic                         out_ready_i,
	output logic [WIDTH-1:0]                  out_data_o,
	output logic [$clog2(DEPTH+1)-1:0]        level_o
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	localparam logic [CW-1:0] FULL_LEVEL = CW'(DEPTH);
	localparam logic [AW-1:0] LAST_SLOT  = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [CW-1:0]    count;
	logic             push;
	logic             pop;
	logic [AW-1:0]    next_rd;
	logic [WIDTH-1:0] head;

	assign in_ready_o  = (count != FULL_LEVEL);
	assign out_valid_o = (count != '0);
	assign out_data_o  = head;
	assign next_rd     = !pop ? rd_ptr : (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
	assign level_o     = count;
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	// Storage carries no reset; only pointers decide what is valid
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	// Head word from a register; a push into the coming head slot bypasses the array
	always_ff @(posedge clk_i) begin
		head <= (push && wr_ptr == next_rd) ? in_data_i : mem[next_rd];
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else if (flush_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + CW'(push) - CW'(pop);
		end
	end
endmodule

// >>> universal_shift_storage_reg8.sv
// Eight-bit universal shift/storage register with shared bus pins and APB access
// ----------------------------------------------------------------------------
// How it works
// - Eight flip-flop bits change on the rising edge of the clock, and at once when reset_n_i goes low.
// - The two select inputs pick the operation done at each edge while clear is off.
// - A low synchronous clear overrides the selects and zeroes all bits at the third rising edge after it goes low.
// - Apart from clear there are exactly four operations: hold, right, left and load.
// - Parallel load captures each shared bus pin into its register bit, or the next preset word when preset_src is set and the FIFO is not empty.
// - Shift right puts the right serial input in bit 0 and moves bit n to bit n+1.
// - Shift left puts the left serial input in bit 7 and moves bit n to bit n-1.
// - The register bits are driven onto the shared bus pins while the drivers are on.
// - Either active-low drive enable high turns the shared bus drivers off.
// - Both selects high also turn the shared bus drivers off, ready for a load.
// - Shift, load, hold and clear keep working while the drivers are off.
// - Bit 0 and bit 7 are driven all the time on two serial taps for cascading.
// ----------------------------------------------------------------------------
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`include "shift_storage_cfg.svh"

module universal_shift_storage_reg8 #(
	parameter int WIDTH      = `SSR_WIDTH,
	parameter int FIFO_DEPTH = `SSR_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                       mclk_i,
	input  wire logic                       reset_n_i,
	// Control pins
	input  wire logic                       sync_clear_n_i,
	input  wire logic                       op_select_hi_i,
	input  wire logic                       op_select_lo_i,
	input  wire logic                       pin_drive_en_a_n_i,
	input  wire logic                       pin_drive_en_b_n_i,
	// Serial pins
	input  wire logic                       serial_in_right_i,
	input  wire logic                       serial_in_left_i,
	output logic                            tap_bit_low_o,
	output logic                            tap_bit_high_o,
	// Shared bus pins
	input  wire logic [WIDTH-1:0]           shared_bus_pins_i,
	output logic [WIDTH-1:0]                shared_bus_pins_o,
	output logic                            shared_bus_pins_oe_o,
	// APB slave
	input  wire logic                       psel_i,
	input  wire logic                       penable_i,
	input  wire logic                       pwrite_i,
	input  wire logic [`SSR_ADDR_WIDTH-1:0] paddr_i,
	input  wire logic [31:0]                pwdata_i,
	output logic [31:0]                     prdata_o,
	output logic                            pready_o,
	output logic                            pslverr_o
);
	localparam int LW = $clog2(FIFO_DEPTH + 1);

	// ------------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------------
	function automatic logic drivers_on(input logic en_a_n, input logic en_b_n,
			input shift_storage_pkg::op_mode_e mode);
		drivers_on = !en_a_n && !en_b_n && (mode != shift_storage_pkg::MODE_LOAD);
	endfunction

	function automatic logic addr_mapped(input logic [`SSR_ADDR_WIDTH-1:0] a);
		addr_mapped = (a == `SSR_ADDR_CTRL) || (a == `SSR_ADDR_STATUS) ||
			(a == `SSR_ADDR_PRESET) || (a == `SSR_ADDR_LOADS);
	endfunction

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------
	shift_storage_pkg::pin_sample_s pins_meta;
	shift_storage_pkg::pin_sample_s pins;
	shift_storage_pkg::pin_sample_s pins_raw;
	shift_storage_pkg::op_mode_e    mode;

	assign pins_raw = '{
		sync_clear_n:     sync_clear_n_i,
		op_select_hi:     op_select_hi_i,
		op_select_lo:     op_select_lo_i,
		pin_drive_en_a_n: pin_drive_en_a_n_i,
		pin_drive_en_b_n: pin_drive_en_b_n_i,
		serial_in_right:  serial_in_right_i,
		serial_in_left:   serial_in_left_i,
		shared_bus_pins:  shared_bus_pins_i
	};

	// Clear and enables reset to their inactive level
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pins_meta <= '{sync_clear_n: 1'b1, pin_drive_en_a_n: 1'b1,
				pin_drive_en_b_n: 1'b1, default: '0};
			pins      <= '{sync_clear_n: 1'b1, pin_drive_en_a_n: 1'b1,
				pin_drive_en_b_n: 1'b1, default: '0};
		end else begin
			pins_meta <= pins_raw;
			pins      <= pins_meta;
		end
	end

	assign mode = shift_storage_pkg::op_mode_e'({pins.op_select_hi, pins.op_select_lo});

	// ------------------------------------------------------------------------
	// Preset FIFO
	// ------------------------------------------------------------------------
	logic             preset_src;
	logic             fifo_flush;
	logic             fifo_in_valid;
	logic             fifo_in_ready;
	logic             fifo_out_valid;
	logic             fifo_take;
	logic [WIDTH-1:0] fifo_out_data;
	logic [LW-1:0]    fifo_level;

	// Preset words replace the pins only when a load actually happens
	assign fifo_take = pins.sync_clear_n && (mode == shift_storage_pkg::MODE_LOAD) &&
		preset_src && fifo_out_valid;

	preset_fifo #(
		.WIDTH (WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_preset_fifo (
		.clk_i       (mclk_i),
		.reset_n_i   (reset_n_i),
		.flush_i     (fifo_flush),
		.in_valid_i  (fifo_in_valid),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (pwdata_i[WIDTH-1:0]),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (fifo_take),
		.out_data_o  (fifo_out_data),
		.level_o     (fifo_level)
	);

	// ------------------------------------------------------------------------
	// Storage bits
	// ------------------------------------------------------------------------
	logic [WIDTH-1:0] bits;
	logic [WIDTH-1:0] next_bits;
	logic [WIDTH-1:0] load_word;

	// Pins are only valid for a load because the far side drives them then
	assign load_word = fifo_take ? fifo_out_data : pins.shared_bus_pins;

	for (genvar n = 0; n < WIDTH; n++) begin : g_stage
		logic from_low;
		logic from_high;
		assign from_low  = (n == 0) ? pins.serial_in_right : bits[(n == 0) ? 0 : n - 1];
		assign from_high = (n == WIDTH - 1) ? pins.serial_in_left :
			bits[(n == WIDTH - 1) ? n : n + 1];
		always_comb begin
			if (!pins.sync_clear_n) begin
				next_bits[n] = 1'b0;
			end else begin
				case (mode)
					shift_storage_pkg::MODE_HOLD:  next_bits[n] = bits[n];
					shift_storage_pkg::MODE_RIGHT: next_bits[n] = from_low;
					shift_storage_pkg::MODE_LEFT:  next_bits[n] = from_high;
					shift_storage_pkg::MODE_LOAD:  next_bits[n] = load_word[n];
					default:                       next_bits[n] = bits[n];
				endcase
			end
		end
	end

	// Driver state has no say here, so operations go on with drivers off
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bits <= `SSR_REG_RESET;
		end else begin
			bits <= next_bits;
		end
	end

	// ------------------------------------------------------------------------
	// Pin drivers and taps
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			shared_bus_pins_oe_o <= 1'b0;
		end else begin
			shared_bus_pins_oe_o <= drivers_on(pins.pin_drive_en_a_n,
				pins.pin_drive_en_b_n, mode);
		end
	end

	assign shared_bus_pins_o = bits;
	assign tap_bit_low_o     = bits[0];
	assign tap_bit_high_o    = bits[WIDTH-1];

	// ------------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------------
	logic        access;
	logic        finish;
	logic        hit_preset;
	logic        push_stall;
	logic [15:0] load_count;
	logic [31:0] read_word;

	assign access     = psel_i && penable_i;
	assign finish     = access && pready_o;
	assign hit_preset = (paddr_i == `SSR_ADDR_PRESET);
	// A full FIFO holds the write in its access phase until a load drains it
	assign push_stall    = pwrite_i && hit_preset && !fifo_in_ready;
	assign fifo_in_valid = finish && pwrite_i && hit_preset;
	assign fifo_flush    = finish && pwrite_i && (paddr_i == `SSR_ADDR_CTRL) &&
		pwdata_i[`SSR_CTRL_FLUSH];

	always_comb begin
		read_word = '0;
		case (paddr_i)
			`SSR_ADDR_CTRL: begin
				read_word[`SSR_CTRL_PRESET_SRC] = preset_src;
			end
			`SSR_ADDR_STATUS: begin
				read_word[WIDTH-1:0]             = bits;
				read_word[`SSR_STAT_OE]          = shared_bus_pins_oe_o;
				read_word[`SSR_STAT_FULL]        = !fifo_in_ready;
				read_word[`SSR_STAT_EMPTY]       = !fifo_out_valid;
				read_word[`SSR_STAT_LEVEL_LO +: LW] = fifo_level;
			end
			`SSR_ADDR_LOADS: begin
				read_word[15:0] = load_count;
			end
			default: begin
				read_word = '0;
			end
		endcase
	end

	// Answer one cycle into the access phase; pready and data from flops
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pready_o  <= 1'b0;
			prdata_o  <= '0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= access && !pready_o && !push_stall;
			if (access && !pready_o) begin
				prdata_o  <= pwrite_i ? 32'h0000_0000 : read_word;
				pslverr_o <= !addr_mapped(paddr_i);
			end else begin
				pslverr_o <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			preset_src <= 1'b0;
		end else if (finish && pwrite_i && (paddr_i == `SSR_ADDR_CTRL)) begin
			preset_src <= pwdata_i[`SSR_CTRL_PRESET_SRC];
		end
	end

	// Counter of loads; a load in the same cycle as a software clear restarts the count at one
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			load_count <= `SSR_LOADS_RESET;
		end else if (pins.sync_clear_n && mode == shift_storage_pkg::MODE_LOAD) begin
			load_count <= (finish && pwrite_i && paddr_i == `SSR_ADDR_LOADS) ?
				16'h0001 : load_count + 16'h0001;
		end else if (finish && pwrite_i && paddr_i == `SSR_ADDR_LOADS) begin
			load_count <= `SSR_LOADS_RESET;
		end
	end

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_run(shift_storage_pkg::op_mode_e m);
		pins.sync_clear_n && mode == m;
	endsequence

	sequence s_access_wait;
		access && !pready_o && !push_stall;
	endsequence

	a_clear_zeroes:
	assert property (!pins.sync_clear_n |=> bits == '0)
		else $error("clear did not zero the register");

	a_hold_keeps:
	assert property (s_run(shift_storage_pkg::MODE_HOLD) |=> $stable(bits))
		else $error("hold changed the register");

	a_shift_right:
	assert property (s_run(shift_storage_pkg::MODE_RIGHT) |=>
		bits == {$past(bits[WIDTH-2:0]), $past(pins.serial_in_right)})
		else $error("right shift wrong");

	a_shift_left:
	assert property (s_run(shift_storage_pkg::MODE_LEFT) |=>
		bits == {$past(pins.serial_in_left), $past(bits[WIDTH-1:1])})
		else $error("left shift wrong");

	a_load_pins:
	assert property (s_run(shift_storage_pkg::MODE_LOAD) ##0 !fifo_take |=>
		bits == $past(pins.shared_bus_pins))
		else $error("load did not take the pins");

	a_drive_enabled:
	assert property (drivers_on(pins.pin_drive_en_a_n, pins.pin_drive_en_b_n, mode)
		|=> shared_bus_pins_oe_o && shared_bus_pins_o == bits)
		else $error("drivers not on");

	a_drive_disabled:
	assert property (pins.pin_drive_en_a_n || pins.pin_drive_en_b_n |=> !shared_bus_pins_oe_o)
		else $error("drivers on while disabled");

	a_load_releases:
	assert property (mode == shift_storage_pkg::MODE_LOAD |=> !shared_bus_pins_oe_o)
		else $error("drivers on during load select");

	a_off_still_shifts:
	assert property (s_run(shift_storage_pkg::MODE_RIGHT) ##0 pins.pin_drive_en_a_n
		##1 s_run(shift_storage_pkg::MODE_RIGHT) |=> tap_bit_high_o == $past(bits[WIDTH-2]))
		else $error("shift stalled with drivers off");

	a_tap_cascade:
	assert property (s_run(shift_storage_pkg::MODE_RIGHT) |=>
		tap_bit_low_o == $past(pins.serial_in_right))
		else $error("low tap does not follow serial input");

	a_change_cause:
	assert property (!$stable(bits) |->
		!$past(pins.sync_clear_n) || $past(mode) != shift_storage_pkg::MODE_HOLD)
		else $error("register changed without a cause");

	a_apb_answer:
	assert property (s_access_wait |=> pready_o ##1 !pready_o)
		else $error("apb answer not one cycle into access");

	a_push_room:
	assert property (fifo_in_valid |-> fifo_in_ready)
		else $error("push into a full fifo");
endmodule

// >>> bus_partner.sv
// Far-side model: shared bus wire with an outside load driver
`timescale 1ns/1ps
module bus_partner (
	// Clock
	input  wire logic       clk_i,
	// Device side
	input  wire logic       dev_oe_i,
	input  wire logic [7:0] dev_data_i,
	// Outside driver
	input  wire logic       drive_req_i,
	input  wire logic [7:0] load_data_i,
	// Resolved wire
	output logic [7:0]      wire_o
);
	logic [7:0] last = 8'h00;

	// ------------------------------------------------------------------------
	// Wire resolution
	// ------------------------------------------------------------------------
	// No pull on the wire: a floating bus toggles so stale data never passes
	always_ff @(posedge clk_i) begin
		last <= wire_o;
	end

	always_comb begin
		if (dev_oe_i) begin
			wire_o = dev_data_i;
		end else if (drive_req_i) begin
			wire_o = load_data_i;
		end else begin
			wire_o = ~last;
		end
	end
endmodule

// >>> tb.sv
// Self-checking bench of the shift/storage register
`timescale 1ns/1ps
module tb;
	typedef struct {
		logic [7:0]                    st;
		shift_storage_pkg::op_mode_e   m;
		int                            n;
		logic                          r;
		logic                          l;
		logic [7:0]                    ex;
	} row_s;

	logic        mclk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        clr_n = 1'b1;
	logic [1:0]  sel = 2'b00;
	logic        en_a_n = 1'b1;
	logic        en_b_n = 1'b1;
	logic        s_r = 1'b0;
	logic        s_l = 1'b0;
	logic        p_req = 1'b0;
	logic [7:0]  p_data = 8'h00;
	logic [7:0]  bus_w;
	logic [7:0]  bus_o;
	logic        oe;
	logic        tap_lo;
	logic        tap_hi;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] rd;
	logic        err;
	int          n_fail = 0;
	int          total_checks = 0;
	row_s        rows[8];

	always #2 mclk_i = ~mclk_i;

	universal_shift_storage_reg8 dut (
		.mclk_i(mclk_i), .reset_n_i(reset_n_i), .sync_clear_n_i(clr_n),
		.op_select_hi_i(sel[1]), .op_select_lo_i(sel[0]),
		.pin_drive_en_a_n_i(en_a_n), .pin_drive_en_b_n_i(en_b_n),
		.serial_in_right_i(s_r), .serial_in_left_i(s_l),
		.tap_bit_low_o(tap_lo), .tap_bit_high_o(tap_hi),
		.shared_bus_pins_i(bus_w), .shared_bus_pins_o(bus_o), .shared_bus_pins_oe_o(oe),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr)
	);

	bus_partner partner (
		.clk_i(mclk_i), .dev_oe_i(oe), .dev_data_i(bus_o),
		.drive_req_i(p_req), .load_data_i(p_data), .wire_o(bus_w)
	);

	// ------------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge mclk_i);
	endtask

	// Holds the request until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int t;
		t = 0;
		@(posedge mclk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk_i);
		penable <= 1'b1;
		do begin
			@(posedge mclk_i);
			t++;
		end while (pready !== 1'b1 && t < 1000);
		if (t >= 1000) begin
			chk(32'h1, 32'h0, "apb wait");
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Pipeline delay is the same for every pin, so n edges of a mode give n operations
	task automatic run_mode(input logic [1:0] m, input int n);
		@(posedge mclk_i);
		sel <= m;
		step(n);
		sel <= 2'b00;
		step(6);
	endtask

	task automatic load(input logic [7:0] d);
		p_req <= 1'b1;
		p_data <= d;
		run_mode(2'b11, 1);
		p_req <= 1'b0;
	endtask

	task automatic chk_reg(input logic [7:0] e);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd[7:0], e, "register");
		chk(tap_lo, e[0], "low tap");
		chk(tap_hi, e[7], "high tap");
	endtask

	// ------------------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------------------
	initial begin
		rows[0] = '{8'ha5, shift_storage_pkg::MODE_RIGHT, 1, 1'b1, 1'b0, 8'h4b};
		rows[1] = '{8'ha5, shift_storage_pkg::MODE_RIGHT, 3, 1'b0, 1'b1, 8'h28};
		rows[2] = '{8'ha5, shift_storage_pkg::MODE_LEFT, 1, 1'b0, 1'b1, 8'hd2};
		rows[3] = '{8'h3c, shift_storage_pkg::MODE_LEFT, 2, 1'b1, 1'b0, 8'h0f};
		rows[4] = '{8'h3c, shift_storage_pkg::MODE_HOLD, 4, 1'b1, 1'b1, 8'h3c};
		rows[5] = '{8'h81, shift_storage_pkg::MODE_RIGHT, 8, 1'b1, 1'b0, 8'hff};
		rows[6] = '{8'h81, shift_storage_pkg::MODE_LEFT, 8, 1'b0, 1'b1, 8'hff};
		rows[7] = '{8'h3c, shift_storage_pkg::MODE_LOAD, 1, 1'b0, 1'b0, 8'hc3};
		step(10);
		reset_n_i <= 1'b1;
		step(2);
		chk_reg(8'h00);
		chk(oe, 1'b0, "oe after reset");
		foreach (rows[i]) begin
			load(rows[i].st);
			step(1);
			s_r <= rows[i].r;
			s_l <= rows[i].l;
			// Load rows take the inverse of the start value from the far side
			p_req <= (rows[i].m == shift_storage_pkg::MODE_LOAD);
			p_data <= ~rows[i].st;
			run_mode(rows[i].m, rows[i].n);
			p_req <= 1'b0;
			chk_reg(rows[i].ex);
		end
		// Clear wins over a load, with drivers off
		load(8'hff);
		step(1);
		clr_n <= 1'b0;
		p_req <= 1'b1;
		p_data <= 8'h55;
		run_mode(2'b11, 1);
		clr_n <= 1'b1;
		p_req <= 1'b0;
		chk_reg(8'h00);
		// Drive enables, each one alone turns drivers off
		load(8'h96);
		for (int i = 0; i < 4; i++) begin
			{en_a_n, en_b_n} <= i[1:0];
			step(6);
			chk(oe, i == 0, "oe by enables");
			if (i == 0) begin
				chk(bus_o, 8'h96, "bus drive");
			end
		end
		// Load select turns drivers off, then outside data is captured
		en_a_n <= 1'b0;
		en_b_n <= 1'b0;
		p_req <= 1'b1;
		p_data <= 8'h69;
		sel <= 2'b11;
		step(8);
		chk(oe, 1'b0, "oe in load");
		sel <= 2'b00;
		p_req <= 1'b0;
		step(6);
		chk(oe, 1'b1, "oe after load");
		chk_reg(8'h69);
		en_a_n <= 1'b1;
		en_b_n <= 1'b1;
		// Register bus: unmapped place, read-only status, load counter
		apb(1'b0, 12'h010, 32'h0);
		chk(err, 1'b1, "unmapped err");
		chk(rd, 32'h0, "unmapped data");
		apb(1'b1, 12'h004, 32'hffff_ffff);
		chk_reg(8'h69);
		apb(1'b1, 12'h00c, 32'h0);
		load(8'h11);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h1, "load count");
		// Preset FIFO: fill to full, drain by loads
		for (int i = 0; i < 16; i++) begin
			apb(1'b1, 12'h008, 32'h10 + i);
		end
		apb(1'b0, 12'h004, 32'h0);
		chk(rd[10:9], 2'b01, "fifo full");
		apb(1'b1, 12'h000, 32'h1);
		// A push into the full FIFO waits in its access phase until a load makes room
		fork
			apb(1'b1, 12'h008, 32'h20);
			run_mode(2'b11, 1);
		join
		chk_reg(8'h10);
		apb(1'b0, 12'h004, 32'h0);
		chk(err, 1'b0, "mapped err");
		chk(rd[15:11], 5'd16, "fifo level");
		run_mode(2'b11, 16);
		chk_reg(8'h20);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd[10:9], 2'b10, "fifo empty");
		// Flush drops queued words; the flush bit reads back as zero
		apb(1'b1, 12'h008, 32'h77);
		apb(1'b1, 12'h000, 32'h3);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h1, "ctrl readback");
		apb(1'b0, 12'h004, 32'h0);
		chk(rd[15:9], 7'h02, "fifo flushed");
		// Reset in mid-run: register, taps and control go back to zero
		load(8'hc3);
		chk_reg(8'hc3);
		reset_n_i <= 1'b0;
		step(2);
		reset_n_i <= 1'b1;
		step(2);
		chk_reg(8'h00);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0, "ctrl after reset");
		conclude();
	end

	// Whole run is a few hundred cycles; this is far beyond it
	initial begin
		repeat (30000) @(posedge mclk_i);
		n_fail++;
		conclude();
	end
endmodule
